// ---- slfm_monitor.sv ----
`timescale 1ns/100ps
module slfm_monitor
    import slfm_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = 300000,
    parameter int unsigned TOL_CYC     = 500,
    parameter int unsigned BLINK_CNT   = BLINK_CYC
)(
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             rx_strobe,
    input  wire logic             link_up_req,
    input  wire logic             sync_done,
    input  wire logic             init_start,
    input  wire logic             init_fail_in,
    input  wire logic             alarm_clear,
    input  wire logic [CYC_W-1:0] comm_cycle_setting,
    output logic                  link_running,
    output logic                  sync_established,
    output logic                  hold_last_data,
    output slfm_alarm_s           alarm,
    output logic                  link_status_lamp_red,
    output logic                  link_status_lamp_green
);
    slfm_link_e       link, next_link;
    logic             sync, next_sync;
    logic             hold, next_hold;
    logic [CYC_W-1:0] gap, next_gap;
    logic             t_al, next_t_al;
    logic             i_al, next_i_al;
    logic             c_al, next_c_al;
    logic [BLINK_W-1:0] bl, next_bl;
    logic             ph, next_ph;
    logic             red, next_red, grn, next_grn;
    logic [CODE_W-1:0] maj, next_maj;
    logic [3:0]       mnr, next_mnr;
    logic [2:0]       s_sync, next_s_sync;
    logic             strobe_ev;
    logic             prev_s, next_prev_s;
    logic             run, next_run;
    logic             armed, next_armed;
    logic             init_win, next_init_win;

    // Strobe is from another device: three stages, act when last two agree
    always_comb
    begin
        next_s_sync = {s_sync[1:0], rx_strobe};
        next_prev_s = prev_s;
        if (s_sync[2] == s_sync[1])
            next_prev_s = s_sync[2];
        // A one-cycle glitch never reaches two agreeing stages
        strobe_ev = (s_sync[2] == s_sync[1]) && s_sync[2] && !prev_s;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s_sync <= '0;
            prev_s <= 1'b0;
        end
        else
        begin
            s_sync <= next_s_sync;
            prev_s <= next_prev_s;
        end
    end

    always_comb
    begin
        next_link = link;
        next_sync = sync;
        next_hold = 1'b0;
        next_gap  = gap;
        next_t_al = t_al;
        next_i_al = i_al;
        next_c_al = c_al;
        next_maj  = maj;
        next_mnr  = mnr;
        next_armed    = armed;
        next_init_win = init_win;
        // Clear first so that a same-cycle alarm event still lands
        if (alarm_clear && !init_fail_in)
        begin
            next_t_al = 1'b0;
            next_c_al = 1'b0;
        end
        if (init_start)
        begin
            next_i_al     = 1'b0;
            next_init_win = 1'b1;
        end
        // Only a power-up or reset-command restart may raise this alarm
        if (init_fail_in && next_init_win && link == SLFM_LINK_INITIAL && !sync)
        begin
            next_i_al     = 1'b1;
            next_init_win = 1'b0;
        end
        if (link == SLFM_LINK_INITIAL)
        begin
            next_gap   = '0;
            next_armed = 1'b0;
            if (sync_done && !i_al)
            begin
                next_sync     = 1'b1;
                next_init_win = 1'b0;
            end
            if (link_up_req && sync && !i_al && !t_al && !c_al)
                next_link = SLFM_LINK_RUNNING;
        end
        else if (sync)
        begin
            if (strobe_ev)
            begin
                // Interval must sit within tolerance of the configured cycle
                // Interval is gap plus one; first strobe after entry has no reference
                if (armed && ((gap + CYC_W'(1) + CYC_W'(TOL_CYC) < comm_cycle_setting) ||
                    (gap + CYC_W'(1) > comm_cycle_setting + CYC_W'(TOL_CYC))))
                    next_c_al = 1'b1;
                next_gap   = '0;
                next_armed = 1'b1;
            end
            else
            begin
                next_gap  = gap + 1'b1;
                next_hold = gap >= comm_cycle_setting;
                if (gap >= CYC_W'(TIMEOUT_CYC - 1))
                    next_t_al = 1'b1;
            end
            if (next_t_al || next_c_al)
            begin
                next_link = SLFM_LINK_INITIAL;
                next_sync = 1'b0;
                next_hold = 1'b0;
            end
        end
        next_run = (next_link == SLFM_LINK_RUNNING);
        // Priority: init alarm shown over timeout over cycle
        if (next_i_al)
        begin
            next_maj = CODE_INIT;
            next_mnr = CODE_MINOR_INIT;
        end
        else if (next_t_al)
        begin
            next_maj = CODE_TIMEOUT;
            next_mnr = CODE_MINOR_TIMEOUT;
        end
        else if (next_c_al)
        begin
            next_maj = CODE_CYCLE;
            next_mnr = CODE_MINOR_CYCLE;
        end
        else
        begin
            next_maj = CODE_NONE;
            next_mnr = CODE_MINOR_NONE;
        end
    end

    always_comb
    begin
        next_bl = bl;
        next_ph = ph;
        if (bl >= BLINK_W'(BLINK_CNT - 1))
        begin
            next_bl = '0;
            next_ph = !ph;
        end
        else
            next_bl = bl + 1'b1;
        next_red = i_al || ((t_al || c_al) && ph);
        next_grn = !i_al && !t_al && !c_al && link == SLFM_LINK_RUNNING;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            link <= SLFM_LINK_INITIAL;
            sync <= 1'b0;
            hold <= 1'b0;
            gap  <= '0;
            t_al <= 1'b0;
            i_al <= 1'b0;
            c_al <= 1'b0;
            maj  <= CODE_NONE;
            mnr  <= CODE_MINOR_NONE;
            run  <= 1'b0;
            armed <= 1'b0;
            // Power-up opens the init check window
            init_win <= 1'b1;
        end
        else
        begin
            link <= next_link;
            sync <= next_sync;
            hold <= next_hold;
            gap  <= next_gap;
            t_al <= next_t_al;
            i_al <= next_i_al;
            c_al <= next_c_al;
            maj  <= next_maj;
            mnr  <= next_mnr;
            run  <= next_run;
            armed <= next_armed;
            init_win <= next_init_win;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bl  <= '0;
            ph  <= 1'b0;
            red <= 1'b0;
            grn <= 1'b0;
        end
        else
        begin
            bl  <= next_bl;
            ph  <= next_ph;
            red <= next_red;
            grn <= next_grn;
        end
    end

    always_comb
    begin
        link_running           = run;
        sync_established       = sync;
        hold_last_data         = hold;
        alarm.timeout          = t_al;
        alarm.init_fail        = i_al;
        alarm.cycle_err        = c_al;
        alarm.code_major       = maj;
        alarm.code_minor       = mnr;
        link_status_lamp_red   = red;
        link_status_lamp_green = grn;
    end
endmodule : slfm_monitor

// ---- slfm_pkg.sv ----
// What this block does
// - Timeout alarm when receive strobe stays absent
// - Timeout checked only running and synchronised
// - Keep last received data until alarm
// - Timeout alarm sends link to INITIAL
// - Timeout alarm drops sync to asynchronous
// - Alarm when initialization sync fails
// - Init check only at powerup, reset command
// - Init failure aborts, holds INITIAL state
// - Cycle alarm on irregular strobe interval
// - Timeout has its own alarm code
package slfm_pkg;
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned CYC_W         = 20;
    localparam int unsigned CODE_W        = 8;
    // Alarm codes as major.minor packed nibble-wise
    localparam logic [CODE_W-1:0] CODE_NONE    = 8'h00;
    localparam logic [CODE_W-1:0] CODE_TIMEOUT = 8'h84;
    localparam logic [CODE_W-1:0] CODE_INIT    = 8'h84;
    localparam logic [CODE_W-1:0] CODE_CYCLE   = 8'h84;
    localparam logic [3:0]  CODE_MINOR_NONE    = 4'h0;
    localparam logic [3:0]  CODE_MINOR_TIMEOUT = 4'h0;
    localparam logic [3:0]  CODE_MINOR_INIT    = 4'h3;
    localparam logic [3:0]  CODE_MINOR_CYCLE   = 4'h5;
    localparam int unsigned BLINK_US      = 250;
    localparam int unsigned BLINK_CYC     = BLINK_US * CLK_MHZ;
    localparam int unsigned BLINK_W       = 16;
    typedef enum logic [1:0] {SLFM_LINK_INITIAL, SLFM_LINK_RUNNING} slfm_link_e;
    typedef enum logic [1:0] {SLFM_LAMP_OFF, SLFM_LAMP_GREEN, SLFM_LAMP_RED, SLFM_LAMP_RED_FLASH} slfm_lamp_e;
    typedef struct packed {
        logic            timeout;
        logic            init_fail;
        logic            cycle_err;
        logic [CODE_W-1:0] code_major;
        logic [3:0]      code_minor;
    } slfm_alarm_s;
endpackage : slfm_pkg

// ---- slfm_chk_monitor.sv ----
`timescale 1ns/100ps
module slfm_chk
    import slfm_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = 300000
)(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        rx_strobe,
    input wire logic        alarm_clear,
    input wire logic        init_start,
    input wire logic        init_fail_in,
    input wire logic        link_running,
    input wire logic        sync_established,
    input wire slfm_alarm_s alarm
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [31:0] quiet;
    // Slack of 8 covers the strobe synchroniser
    always_ff @(posedge clock)
        quiet <= (sys_rst || rx_strobe || !link_running) ? '0 : quiet + 1;
    property p_bound; quiet <= TIMEOUT_CYC + 8; endproperty
    a_bound: assert property (p_bound) else $error("no timeout");
    property p_gate; $rose(alarm.timeout) |-> $past(link_running) && $past(sync_established); endproperty
    a_gate: assert property (p_gate) else $error("timeout gated");
    property p_link; $rose(alarm.timeout) |-> !link_running; endproperty
    a_link: assert property (p_link) else $error("link kept");
    property p_sync; $rose(alarm.timeout) |-> !sync_established; endproperty
    a_sync: assert property (p_sync) else $error("sync kept");
    property p_code; alarm[14:12] == 3'b100 |-> alarm[11:0] == {CODE_TIMEOUT, CODE_MINOR_TIMEOUT}; endproperty
    a_code: assert property (p_code) else $error("code");
    property p_hold; alarm.init_fail |-> !link_running; endproperty
    a_hold: assert property (p_hold) else $error("init run");
    property p_stick; alarm.init_fail && !init_start |=> alarm.init_fail; endproperty
    a_stick: assert property (p_stick) else $error("init lost");
    // Timeout and cycle alarms only rise while running, and a same-cycle rise beats the clear
    property p_clr; alarm_clear && !init_fail_in && !link_running |=> !alarm.timeout && !alarm.cycle_err; endproperty
    a_clr: assert property (p_clr) else $error("clear");
endmodule : slfm_chk
bind slfm_monitor slfm_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .rx_strobe        (rx_strobe),
    .alarm_clear      (alarm_clear),
    .init_start       (init_start),
    .init_fail_in     (init_fail_in),
    .link_running     (link_running),
    .sync_established (sync_established),
    .alarm            (alarm)
);

// ---- slfm_host.sv ----
`timescale 1ns/100ps
module slfm_host
    import slfm_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             run,
    input  wire logic             odd,
    input  wire logic [CYC_W-1:0] period,
    output logic                  rx_strobe
);
    logic [CYC_W-1:0] cnt = '0;
    wire  [CYC_W-1:0] lim = odd ? period + (period >> 1) : period;
    always @(posedge clock)
    begin
        cnt       <= (run && cnt < lim - 1'b1) ? cnt + 1'b1 : '0;
        // Two cycles wide so the receiver's agreeing stages accept it
        rx_strobe <= run && cnt < 20'h00002;
    end
endmodule : slfm_host

// ---- slfm_monitor_bench.sv ----
`timescale 1ns/100ps
module slfm_monitor_bench
    import slfm_pkg::*;
;
    logic clock = 0, sys_rst = 1, link_up_req = 0, sync_done = 0, init_start = 0;
    logic init_fail_in = 0, alarm_clear = 0, run = 0, odd = 0, rx_strobe, lr, se, hl, red, grn;
    slfm_alarm_s alarm;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    slfm_host host (.clock(clock), .run(run), .odd(odd), .period(20'h0000a), .rx_strobe(rx_strobe));
    slfm_monitor #(.TIMEOUT_CYC(50), .TOL_CYC(2), .BLINK_CNT(4)) dut (.clock(clock), .sys_rst(sys_rst),
        .rx_strobe(rx_strobe), .link_up_req(link_up_req), .sync_done(sync_done), .init_start(init_start),
        .init_fail_in(init_fail_in), .alarm_clear(alarm_clear), .comm_cycle_setting(20'h0000a),
        .link_running(lr), .sync_established(se), .hold_last_data(hl), .alarm(alarm),
        .link_status_lamp_red(red), .link_status_lamp_green(grn));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
        cyc(2);
    endtask : pulse
    task automatic t_init;
        pulse(init_fail_in);
        chk("init", {3'b010, CODE_INIT, CODE_MINOR_INIT}, alarm);
        pulse(alarm_clear);
        link_up_req = 1;
        cyc(9);
        chk("stuck", 3'b101, {alarm.init_fail, lr, red});
        link_up_req = 0;
        pulse(init_start);
        chk("restart", 0, alarm);
    endtask : t_init
    task automatic t_link;
        run = 1;
        pulse(sync_done);
        link_up_req = 1;
        cyc(3);
        link_up_req = 0;
        cyc(60);
        chk("link", 15'h0007, {alarm, lr, se, grn});
    endtask : t_link
    task automatic t_timeout;
        logic r;
        run = 0;
        cyc(20);
        chk("hold", 2'b11, {hl, lr});
        cyc(50);
        chk("lost", {3'b100, CODE_TIMEOUT, CODE_MINOR_TIMEOUT}, alarm);
        chk("down", 0, {lr, se, grn});
        r = red;
        cyc(4);
        chk("flash", !r, red);
        pulse(alarm_clear);
        chk("cleared", 0, alarm.timeout);
        pulse(init_fail_in);
        chk("nowin", 0, alarm.init_fail);
    endtask : t_timeout
    task automatic t_cycle;
        odd = 1;
        cyc(60);
        chk("cyc", {3'b001, CODE_CYCLE, CODE_MINOR_CYCLE}, alarm);
        odd = 0;
        pulse(alarm_clear);
    endtask : t_cycle
    task automatic t_reset;
        sys_rst = 1;
        cyc(2);
        sys_rst = 0;
        chk("reset", 0, {alarm, lr, se, hl, red, grn});
        pulse(init_fail_in);
        chk("powerup", {3'b010, CODE_INIT, CODE_MINOR_INIT}, alarm);
    endtask : t_reset
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial
    begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        cyc(6);
        sys_rst = 0;
        t_init();
        t_link();
        t_timeout();
        t_link();
        t_cycle();
        t_reset();
        conclude();
    end
endmodule : slfm_monitor_bench
